// [src/link_sync_microcode_loader.sv]
// How it works
// - Each link has four lanes at 444 Mb/s, tracked per lane.
// - One shared controller aligns bit phase and packets for every link.
// - Hunt request from software; far end sends sync packets during alignment.
// - Drift tracking adjusts lane phase one tap at a time while hunting or tracking.
// - Memory is reachable only via address, data and command ports.
// - Instruction memory spans processor addresses 0x800 through 0xfff.
// - Processor address increments after every memory read or write, wrapping from 0xfff to 0x800.
// - While hold-reset is set, the controller stays in reset.
// - Clearing hold-reset starts fetching at address 0x800.
`timescale 1ns/1ps
`default_nettype none
module link_sync_microcode_loader
    import link_sync_pkg::*;
#(
    parameter int NLINKS = LINKS
)(
    // Clock and reset.
    input  wire logic                              I_CLOCK,
    input  wire logic                              I_RSTN,
    // Processor access.
    input  wire link_sync_pkg::proc_cmd_t          I_CMD,
    input  wire logic [link_sync_pkg::ADDR_W-1:0]  I_ADDR,
    input  wire logic [link_sync_pkg::DATA_W-1:0]  I_WDATA,
    output logic      [link_sync_pkg::DATA_W-1:0]  O_RDATA,
    output logic      [link_sync_pkg::ADDR_W-1:0]  O_ADDR,
    // Mode and hunt control.
    input  wire logic                              I_HOLD_RESET,
    input  wire logic                              I_HUNT,
    // Link sampling, per lane.
    input  wire logic [NLINKS*LANES-1:0]           I_SYNC_SEEN,
    input  wire logic [NLINKS*LANES-1:0]           I_EARLY,
    input  wire logic [NLINKS*LANES-1:0]           I_LATE,
    // Status.
    output logic                                   O_RUNNING,
    output logic [link_sync_pkg::ADDR_W-1:0]       O_FETCH_PC,
    output logic                                   O_HUNTING,
    output logic [NLINKS-1:0]                      O_LINK_ALIGNED,
    output logic [NLINKS*LANES*link_sync_pkg::PHASE_W-1:0] O_PHASE
);
    import link_sync_pkg::*;

    localparam int NL = NLINKS * LANES;

    logic [DATA_W-1:0] imem [IMEM_DEPTH];
    logic [ADDR_W-1:0] addr_r;
    logic              hold_s1_r, hold_s2_r, hunt_s1_r, hunt_s2_r;
    logic [NL-1:0]     sync_s1_r, sync_s2_r, early_s1_r, early_s2_r, late_s1_r, late_s2_r;
    ctl_state_t        state_r;
    logic [ADDR_W-1:0] pc_r;
    logic [2:0]        hit_cnt_r [NLINKS];
    logic [NLINKS-1:0] aligned_r;
    logic [PHASE_W-1:0] phase [NL];
    logic              access;
    logic [IMEM_IDX_W-1:0] idx;

    assign access = (I_CMD == CMD_WRITE) || (I_CMD == CMD_READ);
    assign idx    = addr_r[IMEM_IDX_W-1:0];

    // Control ports come from software logic on another timing path, so they are synchronised.
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            hold_s1_r  <= 1'b1;
            hold_s2_r  <= 1'b1;
            hunt_s1_r  <= 1'b0;
            hunt_s2_r  <= 1'b0;
            sync_s1_r  <= '0;
            sync_s2_r  <= '0;
            early_s1_r <= '0;
            early_s2_r <= '0;
            late_s1_r  <= '0;
            late_s2_r  <= '0;
        end else begin
            hold_s1_r  <= I_HOLD_RESET;
            hold_s2_r  <= hold_s1_r;
            hunt_s1_r  <= I_HUNT;
            hunt_s2_r  <= hunt_s1_r;
            sync_s1_r  <= I_SYNC_SEEN;
            sync_s2_r  <= sync_s1_r;
            early_s1_r <= I_EARLY;
            early_s2_r <= early_s1_r;
            late_s1_r  <= I_LATE;
            late_s2_r  <= late_s1_r;
        end
    end

    // Address register: set once, then advances after each access.
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            addr_r <= ADDR_RST;
        end else if (I_CMD == CMD_SET_ADDR) begin
            addr_r <= I_ADDR;
        end else if (access) begin
            addr_r <= (addr_r == IMEM_TOP) ? IMEM_BASE : addr_r + 12'h001;
        end
    end

    // Memory writes land only inside the window and only while the controller is held.
    always_ff @(posedge I_CLOCK) begin
        if (I_CMD == CMD_WRITE && addr_r[ADDR_W-1] && hold_s2_r) begin
            imem[idx] <= I_WDATA;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RDATA <= '0;
        end else if (I_CMD == CMD_READ) begin
            O_RDATA <= addr_r[ADDR_W-1] ? imem[idx] : '0;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_ADDR <= ADDR_RST;
        end else begin
            O_ADDR <= addr_r;
        end
    end

    // Shared controller sequencing.
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_r <= ST_HELD;
        end else if (hold_s2_r) begin
            state_r <= ST_HELD;
        end else begin
            case (state_r)
                ST_HELD: begin
                    state_r <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (hunt_s2_r) begin
                        state_r <= ST_HUNT;
                    end
                end
                ST_HUNT: begin
                    if (&aligned_r) begin
                        state_r <= ST_TRACK;
                    end
                end
                ST_TRACK: begin
                    if (hunt_s2_r) begin
                        state_r <= ST_HUNT;
                    end
                end
                default: begin
                    state_r <= ST_HELD;
                end
            endcase
        end
    end

    // Fetch pointer restarts at the window base and stays there until the controller leaves reset.
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pc_r <= IMEM_BASE;
        end else if (hold_s2_r) begin
            pc_r <= IMEM_BASE;
        end else if (state_r != ST_HELD) begin
            pc_r <= (pc_r == IMEM_TOP) ? IMEM_BASE : pc_r + 12'h001;
        end
    end

    // Packet alignment: a link is aligned after enough sync packets on all its lanes.
    for (genvar l = 0; l < NLINKS; l++) begin : g_link
        always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
            if (!I_RSTN) begin
                hit_cnt_r[l] <= '0;
                aligned_r[l] <= 1'b0;
            end else if (hold_s2_r || state_r == ST_IDLE) begin
                hit_cnt_r[l] <= '0;
                aligned_r[l] <= 1'b0;
            end else if (state_r == ST_HUNT && !aligned_r[l]) begin
                if (&sync_s2_r[l*LANES +: LANES]) begin
                    hit_cnt_r[l] <= hit_cnt_r[l] + 3'h1;
                    aligned_r[l] <= (hit_cnt_r[l] + 3'h1 == SYNC_HITS_CNT);
                end else begin
                    hit_cnt_r[l] <= '0;
                end
            end
        end
    end

    // One tracker per lane, all driven by the one controller.
    for (genvar n = 0; n < NL; n++) begin : g_lane
        lane_phase_tracker u_trk (
            .i_clk    (I_CLOCK),
            .i_rstn   (I_RSTN),
            .i_clear  (hold_s2_r),
            .i_enable (state_r == ST_HUNT || state_r == ST_TRACK),
            .i_early  (early_s2_r[n]),
            .i_late   (late_s2_r[n]),
            .o_phase  (phase[n])
        );
        always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
            if (!I_RSTN) begin
                O_PHASE[n*PHASE_W +: PHASE_W] <= PHASE_RST;
            end else begin
                O_PHASE[n*PHASE_W +: PHASE_W] <= phase[n];
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RUNNING      <= 1'b0;
            O_FETCH_PC     <= IMEM_BASE;
            O_HUNTING      <= 1'b0;
            O_LINK_ALIGNED <= '0;
        end else begin
            O_RUNNING      <= (state_r != ST_HELD);
            O_FETCH_PC     <= pc_r;
            O_HUNTING      <= (state_r == ST_HUNT);
            O_LINK_ALIGNED <= aligned_r;
        end
    end
endmodule
`default_nettype wire

// [common/link_sync_pkg.sv]
package link_sync_pkg;
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 16;
    localparam logic [11:0] IMEM_BASE      = 12'h800;
    localparam logic [11:0] IMEM_TOP       = 12'hfff;
    localparam int          IMEM_DEPTH     = 2048;
    localparam int          IMEM_IDX_W     = 11;
    localparam logic [11:0] ADDR_RST       = 12'h800;
    localparam int          LANES          = 4;
    localparam int          LINKS          = 2;
    localparam int          LANE_RATE_MBPS = 444;
    localparam int          PHASE_W        = 3;
    localparam logic [2:0]  PHASE_RST      = 3'h0;
    localparam int          SYNC_HITS      = 4;
    localparam logic [2:0]  SYNC_HITS_CNT  = 3'h4;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_SET_ADDR,
        CMD_WRITE,
        CMD_READ
    } proc_cmd_t;

    typedef enum {
        ST_HELD,
        ST_IDLE,
        ST_HUNT,
        ST_TRACK
    } ctl_state_t;
endpackage

// [src/lane_phase_tracker.sv]
`timescale 1ns/1ps
`default_nettype none
module lane_phase_tracker
    import link_sync_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    // Control.
    input  wire logic               i_clear,
    input  wire logic               i_enable,
    input  wire logic               i_early,
    input  wire logic               i_late,
    // Result.
    output logic [PHASE_W-1:0]      o_phase
);
    // Drift is followed one tap at a time so live data never jumps more than one tap.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_phase <= PHASE_RST;
        end else if (i_clear) begin
            o_phase <= PHASE_RST;
        end else if (i_enable && i_early && !i_late) begin
            o_phase <= o_phase - 3'h1;
        end else if (i_enable && i_late && !i_early) begin
            o_phase <= o_phase + 3'h1;
        end
    end
endmodule
`default_nettype wire

// [testbench/link_sync_microcode_loader_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module link_sync_microcode_loader_monitor
    import link_sync_pkg::*;
#(
    parameter int NLINKS = LINKS
)(
    input wire logic                                I_CLOCK,
    input wire logic                                I_RSTN,
    input wire proc_cmd_t                           I_CMD,
    input wire logic [ADDR_W-1:0]                   I_ADDR,
    input wire logic [DATA_W-1:0]                   O_RDATA,
    input wire logic [ADDR_W-1:0]                   O_ADDR,
    input wire logic                                I_HOLD_RESET,
    input wire logic                                I_HUNT,
    input wire logic [NLINKS*LANES-1:0]             I_SYNC_SEEN,
    input wire logic                                O_RUNNING,
    input wire logic [ADDR_W-1:0]                   O_FETCH_PC,
    input wire logic                                O_HUNTING,
    input wire logic [NLINKS-1:0]                   O_LINK_ALIGNED
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RSTN);
    function automatic logic [11:0] step(input logic [11:0] a);
        return (a == 12'hfff) ? 12'h800 : a + 12'h001;
    endfunction
    a_held_not_run: assert property (I_HOLD_RESET [*5] |-> !O_RUNNING)
        else $error("controller running while held");
    a_start_at_base: assert property ($rose(O_RUNNING) |-> O_FETCH_PC == 12'h800)
        else $error("fetch did not start at window base");
    a_fetch_counts: assert property (O_RUNNING && $past(O_RUNNING) |-> O_FETCH_PC == step($past(O_FETCH_PC)))
        else $error("fetch pointer did not advance");
    a_addr_step: assert property (I_CMD inside {CMD_WRITE, CMD_READ} |-> ##2 O_ADDR == step($past(O_ADDR)))
        else $error("address did not advance after access");
    a_addr_load: assert property (I_CMD == CMD_SET_ADDR |-> ##2 O_ADDR == $past(I_ADDR, 2))
        else $error("address not loaded");
    a_rdata_holds: assert property ($changed(O_RDATA) |-> $past(I_CMD) == CMD_READ)
        else $error("read data changed without read");
    a_hunt_run_only: assert property ($rose(O_HUNTING) |-> O_RUNNING && $past(I_HUNT, 4))
        else $error("hunting while held or unrequested");
    a_align_needs_sync: assert property ($rose(O_LINK_ALIGNED[0]) |-> $past(&I_SYNC_SEEN[3:0], 4))
        else $error("link aligned without sync");
    cover property ($rose(O_RUNNING));
    cover property (I_CMD == CMD_READ);
    cover property ($rose(O_LINK_ALIGNED[0]));
endmodule
bind link_sync_microcode_loader link_sync_microcode_loader_monitor #(.NLINKS(NLINKS)) mon_u (
    .I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_CMD(I_CMD), .I_ADDR(I_ADDR), .O_RDATA(O_RDATA),
    .O_ADDR(O_ADDR), .I_HOLD_RESET(I_HOLD_RESET), .I_HUNT(I_HUNT), .I_SYNC_SEEN(I_SYNC_SEEN),
    .O_RUNNING(O_RUNNING), .O_FETCH_PC(O_FETCH_PC), .O_HUNTING(O_HUNTING),
    .O_LINK_ALIGNED(O_LINK_ALIGNED));
`default_nettype wire

// [testbench/link_sync_microcode_loader_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module link_sync_microcode_loader_bench;
    import link_sync_pkg::*;
    logic        clk, rstn, hold, hunt, run, hunting;
    proc_cmd_t   cmd;
    logic [11:0] addr, o_addr, pc;
    logic [15:0] wdata, rdata, lf;
    logic [7:0]  sync, early, late;
    logic [1:0]  aligned;
    logic [23:0] phase;
    logic [23:0] ph0;
    logic [2:0]  ex;
    logic [15:0] mem [int];
    int          ea, n_mismatch, compares, cyc, i;
    link_sync_microcode_loader #(.NLINKS(2)) dut_u (.I_CLOCK(clk), .I_RSTN(rstn), .I_CMD(cmd),
        .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_ADDR(o_addr), .I_HOLD_RESET(hold),
        .I_HUNT(hunt), .I_SYNC_SEEN(sync), .I_EARLY(early), .I_LATE(late), .O_RUNNING(run),
        .O_FETCH_PC(pc), .O_HUNTING(hunting), .O_LINK_ALIGNED(aligned), .O_PHASE(phase));
    always #50 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chkd(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task chkf(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // The model applies each command at the edge that samples it.
    task op(input proc_cmd_t c, input logic [11:0] a, input logic [15:0] d);
        logic [15:0] e;
        cmd = c;
        addr = a;
        wdata = d;
        e = (ea >= 32'h800 && mem.exists(ea)) ? mem[ea] : 16'h0;
        @(posedge clk);
        #1;
        if (c == CMD_SET_ADDR) ea = a;
        else if (c != CMD_NONE) begin
            if (c == CMD_WRITE && ea >= 32'h800 && hold) mem[ea] = d;
            if (c == CMD_READ) chkd(rdata, e);
            ea = (ea == 32'hfff) ? 32'h800 : ea + 1;
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop;
        end
    end
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        hold = 1'b1;
        hunt = 1'b0;
        cmd = CMD_NONE;
        {addr, wdata, sync, early, late} = '0;
        {ea, lf, n_mismatch, compares, cyc} = '0;
        ea = 32'h800;
        lf = 16'h1967;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        chkd({4'h0, o_addr}, 16'h0800);
        chkd({4'h0, pc}, 16'h0800);
        chkf(run, 1'b0);
        repeat (2) op(CMD_NONE, 12'h0, 16'h0);
        op(CMD_SET_ADDR, 12'h800, 16'h0);
        for (i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            op(CMD_WRITE, 12'h0, lf);
        end
        op(CMD_SET_ADDR, 12'hfff, 16'h0);
        op(CMD_WRITE, 12'h0, ~lf);
        op(CMD_WRITE, 12'h0, lf ^ 16'h00ff);
        op(CMD_SET_ADDR, 12'h7fe, 16'h0);
        op(CMD_WRITE, 12'h0, 16'hbeef);
        op(CMD_READ, 12'h0, 16'h0);
        op(CMD_SET_ADDR, 12'h800, 16'h0);
        for (i = 0; i < 8; i++) op(CMD_READ, 12'h0, 16'h0);
        op(CMD_SET_ADDR, 12'hfff, 16'h0);
        repeat (2) op(CMD_READ, 12'h0, 16'h0);
        repeat (2) op(CMD_NONE, 12'h0, 16'h0);
        chkd({4'h0, o_addr}, ea[15:0]);
        hunt = 1'b1;
        sync = 8'hff;
        {early, late} = lfsr(lf);
        hold = 1'b0;
        for (i = 0; i < 20 && run !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chkf(run, 1'b1);
        chkd({4'h0, pc}, 16'h0800);
        op(CMD_SET_ADDR, 12'h800, 16'h0);
        chkf(hunting, 1'b1);
        op(CMD_WRITE, 12'h0, 16'h5a5a);
        for (i = 0; i < 300 && aligned !== 2'b11; i++) begin
            @(posedge clk);
            #1;
        end
        chkd({14'h0, aligned}, 16'h0003);
        // Every enabled lane told only early or only late moves one tap per cycle that way; others hold.
        ph0 = phase;
        @(posedge clk);
        #1;
        for (i = 0; i < 8; i++) begin
            ex = ph0[i*3 +: 3];
            if (early[i] && !late[i]) ex = ex - 3'h1;
            if (late[i] && !early[i]) ex = ex + 3'h1;
            chkd({13'h0, phase[i*3 +: 3]}, {13'h0, ex});
        end
        hold = 1'b1;
        hunt = 1'b0;
        repeat (6) op(CMD_NONE, 12'h0, 16'h0);
        chkf(run, 1'b0);
        chkf(hunting, 1'b0);
        chkf(|phase, 1'b0);
        chkd({4'h0, pc}, 16'h0800);
        op(CMD_SET_ADDR, 12'h800, 16'h0);
        op(CMD_READ, 12'h0, 16'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
